// ---- hw/asq_params.svh ----
// Constants of the analog acquisition sequencer.
// Assumes a single 100 MHz system clock.
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH

// ----------------------------------------
// Clock and rates
// ----------------------------------------
`define ASQ_CLK_HZ 100000000
`define ASQ_SW_RATE_SPS 50
`define ASQ_SW_RTT_MS 20
`define ASQ_CONT_RATE_SPS 1200
`define ASQ_BURST_RATE_SPS 8000
// Least sample period, rounded up to whole cycles
`define ASQ_CONT_PACE_CYC \
    ((`ASQ_CLK_HZ + `ASQ_CONT_RATE_SPS - 1) / `ASQ_CONT_RATE_SPS)
`define ASQ_BURST_PACE_CYC \
    ((`ASQ_CLK_HZ + `ASQ_BURST_RATE_SPS - 1) / `ASQ_BURST_RATE_SPS)
`define ASQ_PACE_W 17

// ----------------------------------------
// Sample store
// ----------------------------------------
`define ASQ_FIFO_DEPTH 4096
`define ASQ_PTR_W 12
`define ASQ_CNT_W 13
`define ASQ_DATA_W 12
`define ASQ_CHAN_W 3

// ----------------------------------------
// Status indicator timing
// ----------------------------------------
`define ASQ_BLINK_TICK_MS 50
`define ASQ_BLINK_TICK_CYC (`ASQ_CLK_HZ / 1000 * `ASQ_BLINK_TICK_MS)
`define ASQ_TICK_W 23
`define ASQ_FAST_TICKS 2
`define ASQ_SLOW_TICKS 10
`define ASQ_SUB_W 4
`define ASQ_HELLO_BLINKS 3
`define ASQ_BLINK_W 2

`endif

// ---- hw/asq_pkg.sv ----
// Types of the analog acquisition sequencer.
// Assumes asq_params.svh is on the include path.
`include "asq_params.svh"

package asq_pkg;

    typedef enum logic [1:0] {
        ASQ_MODE_SW,
        ASQ_MODE_CONT,
        ASQ_MODE_BURST
    } asq_mode_type;

    typedef enum logic [1:0] {
        ASQ_CMD_SINGLE,
        ASQ_CMD_START,
        ASQ_CMD_STOP
    } asq_cmd_type;

    typedef enum {
        ASQ_IDLE,
        ASQ_ARMED,
        ASQ_RUN,
        ASQ_SINGLE
    } asq_state_type;

    typedef struct packed {
        asq_state_type st;
        asq_mode_type mode;
        logic [1:0] last_idx;
        logic [`ASQ_CHAN_W-1:0] first;
        logic [1:0] idx;
        logic [`ASQ_PACE_W-1:0] pace;
        logic busy;
        logic [`ASQ_PTR_W-1:0] wr;
        logic [`ASQ_PTR_W-1:0] rd;
        logic [`ASQ_CNT_W-1:0] cnt;
        logic conv_start;
        logic [`ASQ_CHAN_W-1:0] conv_chan;
        logic up_valid;
        logic [`ASQ_DATA_W-1:0] up_data;
        logic overrun;
        logic armed;
        logic trig_q;
        logic xfer;
        logic scan;
    } asq_seq_type;

    typedef struct packed {
        logic [`ASQ_TICK_W-1:0] tick;
        logic [`ASQ_SUB_W-1:0] sub;
        logic [`ASQ_BLINK_W-1:0] hello;
        logic hello_off;
        logic comm_q;
        logic phase;
        logic led;
    } asq_led_type;

endpackage

// ---- hw/asq_status_led.sv ----
// Status indicator driver: steady, fast, slow and greeting blinks.
// Assumes synchronous inputs and a single clock.
`include "asq_params.svh"

module asq_status_led #(
    parameter int unsigned TICK_CYC = `ASQ_BLINK_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Conditions
    input wire logic comm_up,
    input wire logic xfer_active,
    input wire logic trig_armed,
    // Indicator
    output logic led
);

    asq_pkg::asq_led_type r;
    asq_pkg::asq_led_type next_r;
    logic tick;
    logic half_fast;
    logic half_slow;
    logic link_rise;

    always_comb begin
        next_r = r;
        tick = (r.tick == `ASQ_TICK_W'(TICK_CYC - 1));
        next_r.tick = tick ? '0 : r.tick + 1'b1;
        half_fast = tick && (r.sub[0] == 1'b1);
        half_slow = tick && (r.sub == `ASQ_SUB_W'(`ASQ_SLOW_TICKS / 2 - 1));
        if (tick) begin
            next_r.sub = half_slow ? '0 : r.sub + 1'b1;
        end
        next_r.comm_q = comm_up;
        link_rise = comm_up && !r.comm_q;
        // Greeting blinks on first contact, from a fresh divider
        if (link_rise) begin
            next_r.tick = '0;
            next_r.sub = '0;
            next_r.hello = `ASQ_BLINK_W'(`ASQ_HELLO_BLINKS);
            next_r.hello_off = 1'b1;
        end else if (r.hello != '0 && half_fast) begin
            next_r.hello_off = !r.hello_off;
            if (!r.hello_off) begin
                next_r.hello = r.hello - 1'b1;
            end
        end
        if (half_fast && r.hello == '0) begin
            next_r.phase = !r.phase;
        end
        if (!comm_up) begin
            next_r.led = 1'b0;
            next_r.hello = '0;
        end else if (link_rise) begin
            next_r.led = 1'b0;
        end else if (r.hello != '0) begin
            next_r.led = !r.hello_off;
        end else if (trig_armed) begin
            if (half_slow) begin
                next_r.led = !r.led;
            end
        end else if (xfer_active) begin
            next_r.led = r.phase;
        end else begin
            next_r.led = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign led = r.led;

endmodule

// ---- hw/asq_sequencer.sv ----
// Analog acquisition sequencer: single, continuous and burst scans.
// Assumes a converter with start/done handshake and a host-side
// stream sink; all inputs synchronous to sys_clk.
//
// How it works
// - Host picks single conversion, continuous scan or burst scan.
// - A single command taken while idle, with no result or sample pending, gives one conversion and one result.
// - Single conversions keep up with 50 per second at 20 ms round trip.
// - Continuous scan stores samples until stopped, dropping them while the store is full, and drains them.
// - Continuous scan paces all channels together at 1.2 kS/s.
// - A scan starts on a host command or an external trigger.
// - Burst scan runs once over 1, 2 or 4 channels into the 4K store.
// - Burst stops at store depth and drains only after capture.
// - Burst scan paces all channels together at 8 kS/s.
// - Indicator is steady while attached with nothing else to show.
// - Indicator blinks while data moves to the host.
// - Indicator blinks three times on first contact, then stays lit.
// - Indicator blinks slowly while armed and blinks fast once the trigger starts the scan.
// - No setting can switch the indicator off.
// - Indicator goes dark on lost contact and lights on return.
`include "asq_params.svh"

module asq_sequencer #(
    parameter int unsigned CONT_PACE_CYC = `ASQ_CONT_PACE_CYC,
    parameter int unsigned BURST_PACE_CYC = `ASQ_BURST_PACE_CYC,
    parameter int unsigned BLINK_TICK_CYC = `ASQ_BLINK_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Host command
    input wire logic cmd_valid,
    input wire asq_pkg::asq_cmd_type cmd_code,
    // Scan setup
    input wire asq_pkg::asq_mode_type cfg_mode,
    input wire logic [1:0] cfg_chan_count,
    input wire logic [`ASQ_CHAN_W-1:0] cfg_first_chan,
    input wire logic cfg_trig_en,
    input wire logic ext_trig,
    // Converter
    output logic conv_start,
    output logic [`ASQ_CHAN_W-1:0] conv_chan,
    input wire logic conv_done,
    input wire logic [`ASQ_DATA_W-1:0] conv_data,
    // Host data stream
    output logic up_valid,
    output logic [`ASQ_DATA_W-1:0] up_data,
    input wire logic up_ready,
    // Status
    output logic scan_busy,
    output logic overrun,
    output logic trig_armed,
    // Link and indicator
    input wire logic host_link_up,
    output logic status_led
);

    asq_pkg::asq_seq_type r;
    asq_pkg::asq_seq_type next_r;
    logic [`ASQ_DATA_W-1:0] mem [0:`ASQ_FIFO_DEPTH-1];
    logic push;
    logic pop;
    logic pace_tick;
    logic trig_rise;
    logic drain_ok;
    logic full;
    logic start_cmd;
    logic stop_cmd;

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb begin
        next_r = r;
        push = 1'b0;
        pop = 1'b0;
        next_r.conv_start = 1'b0;
        next_r.trig_q = ext_trig;
        trig_rise = ext_trig && !r.trig_q;
        full = (r.cnt == `ASQ_CNT_W'(`ASQ_FIFO_DEPTH));
        start_cmd = cmd_valid && (cmd_code == asq_pkg::ASQ_CMD_START);
        stop_cmd = cmd_valid && (cmd_code == asq_pkg::ASQ_CMD_STOP);
        if (r.mode == asq_pkg::ASQ_MODE_BURST) begin
            pace_tick = (r.pace == `ASQ_PACE_W'(BURST_PACE_CYC - 1));
        end else begin
            pace_tick = (r.pace == `ASQ_PACE_W'(CONT_PACE_CYC - 1));
        end
        // Burst data stays put until capture ends
        drain_ok = !(r.mode == asq_pkg::ASQ_MODE_BURST
            && (r.st == asq_pkg::ASQ_RUN || r.st == asq_pkg::ASQ_ARMED));
        if (r.conv_start) begin
            next_r.busy = 1'b1;
        end
        unique case (r.st)
            asq_pkg::ASQ_IDLE: begin
                if (cmd_valid && cmd_code == asq_pkg::ASQ_CMD_SINGLE
                    && !r.up_valid && r.cnt == '0 && !r.busy) begin
                    next_r.st = asq_pkg::ASQ_SINGLE;
                    next_r.mode = asq_pkg::ASQ_MODE_SW;
                    next_r.conv_chan = cfg_first_chan;
                    next_r.conv_start = 1'b1;
                end else if (start_cmd
                    && cfg_mode != asq_pkg::ASQ_MODE_SW) begin
                    next_r.mode = cfg_mode;
                    next_r.first = cfg_first_chan;
                    unique case (cfg_chan_count)
                        2'h0: next_r.last_idx = 2'h0;
                        2'h1: next_r.last_idx = 2'h1;
                        default: next_r.last_idx = 2'h3;
                    endcase
                    next_r.idx = '0;
                    next_r.pace = '0;
                    next_r.overrun = 1'b0;
                    if (cfg_trig_en) begin
                        next_r.st = asq_pkg::ASQ_ARMED;
                        next_r.armed = 1'b1;
                    end else begin
                        next_r.st = asq_pkg::ASQ_RUN;
                    end
                end
                // Conversion still in flight when the scan stopped
                if (conv_done && r.busy
                    && r.mode != asq_pkg::ASQ_MODE_SW) begin
                    if (!full) begin
                        push = 1'b1;
                    end else begin
                        next_r.overrun = 1'b1;
                    end
                end
            end
            asq_pkg::ASQ_ARMED: begin
                if (cmd_valid && cmd_code == asq_pkg::ASQ_CMD_STOP) begin
                    next_r.st = asq_pkg::ASQ_IDLE;
                    next_r.armed = 1'b0;
                end else if (trig_rise) begin
                    next_r.st = asq_pkg::ASQ_RUN;
                    next_r.armed = 1'b0;
                end
            end
            asq_pkg::ASQ_RUN: begin
                next_r.pace = pace_tick ? '0 : r.pace + 1'b1;
                if (pace_tick && !r.busy && !r.conv_start && !stop_cmd) begin
                    next_r.conv_start = 1'b1;
                    next_r.conv_chan = r.first + `ASQ_CHAN_W'(r.idx);
                    next_r.idx = (r.idx == r.last_idx) ? '0 : r.idx + 1'b1;
                end
                if (conv_done && r.busy) begin
                    if (!full) begin
                        push = 1'b1;
                    end else begin
                        next_r.overrun = 1'b1;
                    end
                    if (r.mode == asq_pkg::ASQ_MODE_BURST && r.cnt
                        == `ASQ_CNT_W'(`ASQ_FIFO_DEPTH - 1)) begin
                        next_r.st = asq_pkg::ASQ_IDLE;
                    end
                end
                if (cmd_valid && cmd_code == asq_pkg::ASQ_CMD_STOP) begin
                    next_r.st = asq_pkg::ASQ_IDLE;
                end
            end
            asq_pkg::ASQ_SINGLE: begin
                if (conv_done && r.busy) begin
                    next_r.up_valid = 1'b1;
                    next_r.up_data = conv_data;
                    next_r.st = asq_pkg::ASQ_IDLE;
                end
            end
        endcase
        if (conv_done) begin
            next_r.busy = 1'b0;
        end
        // Host side of the stream
        if (r.up_valid && up_ready && r.st != asq_pkg::ASQ_SINGLE) begin
            next_r.up_valid = 1'b0;
        end
        if ((!r.up_valid || up_ready) && r.cnt != '0 && drain_ok
            && r.st != asq_pkg::ASQ_SINGLE) begin
            pop = 1'b1;
            next_r.up_valid = 1'b1;
            next_r.up_data = mem[r.rd];
            next_r.rd = r.rd + 1'b1;
        end
        if (push) begin
            next_r.wr = r.wr + 1'b1;
        end
        next_r.cnt = r.cnt + `ASQ_CNT_W'(push) - `ASQ_CNT_W'(pop);
        next_r.xfer = next_r.up_valid || next_r.st == asq_pkg::ASQ_RUN
            || next_r.cnt != '0;
        next_r.scan = (next_r.st != asq_pkg::ASQ_IDLE);
    end

    // ----------------------------------------
    // State and sample store
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            r <= '{st: asq_pkg::ASQ_IDLE, mode: asq_pkg::ASQ_MODE_SW,
                default: '0};
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[r.wr] <= conv_data;
        end
    end

    // ----------------------------------------
    // Status indicator, always driven
    // ----------------------------------------
    asq_status_led #(
        .TICK_CYC(BLINK_TICK_CYC)
    ) u_led (
        .sys_clk(sys_clk),
        .srst(srst),
        .comm_up(host_link_up),
        .xfer_active(r.xfer),
        .trig_armed(r.armed),
        .led(status_led)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign conv_start = r.conv_start;
    assign conv_chan = r.conv_chan;
    assign up_valid = r.up_valid;
    assign up_data = r.up_data;
    assign scan_busy = r.scan;
    assign overrun = r.overrun;
    assign trig_armed = r.armed;

endmodule

// ---- verification/asq_chk.sv ----
// Port checker of the acquisition sequencer.
// Assumes it is bound into asq_sequencer; one clock.
`include "asq_params.svh"

module asq_chk #(
    parameter int unsigned CONT_PACE_CYC = 1,
    parameter int unsigned BURST_PACE_CYC = 1,
    parameter int unsigned BLINK_TICK_CYC = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Host side
    input wire logic cmd_valid,
    input wire asq_pkg::asq_cmd_type cmd_code,
    input wire asq_pkg::asq_mode_type cfg_mode,
    input wire logic ext_trig,
    input wire logic host_link_up,
    input wire logic up_ready,
    // Outputs
    input wire logic conv_start,
    input wire logic up_valid,
    input wire logic [`ASQ_DATA_W-1:0] up_data,
    input wire logic scan_busy,
    input wire logic overrun,
    input wire logic trig_armed,
    input wire logic status_led
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start held too long");
    a_cmd_start: assert property (cmd_valid && !scan_busy &&
        cmd_code == asq_pkg::ASQ_CMD_START &&
        cfg_mode != asq_pkg::ASQ_MODE_SW |=> trig_armed || scan_busy)
        else $error("start command not taken");
    a_trig_run: assert property (trig_armed && ext_trig &&
        !$past(ext_trig) && !cmd_valid |=> !trig_armed && scan_busy)
        else $error("trigger did not start the scan");
    a_stop_armed: assert property (cmd_valid && trig_armed &&
        cmd_code == asq_pkg::ASQ_CMD_STOP && !ext_trig |=> !scan_busy)
        else $error("stop did not disarm");
    a_link_dark: assert property (!host_link_up ##1
        !host_link_up |=> !status_led)
        else $error("indicator lit without link");
    a_hello_dark: assert property ($rose(host_link_up)
        |=> !status_led [*5])
        else $error("greeting does not begin dark");
    a_up_hold: assert property (up_valid && !up_ready
        |=> up_valid && $stable(up_data))
        else $error("stream word dropped before taken");
    a_overrun_keep: assert property (overrun && !(cmd_valid &&
        cmd_code == asq_pkg::ASQ_CMD_START) |=> overrun)
        else $error("overrun flag lost");
endmodule

bind asq_sequencer asq_chk #(
    .CONT_PACE_CYC(CONT_PACE_CYC), .BURST_PACE_CYC(BURST_PACE_CYC),
    .BLINK_TICK_CYC(BLINK_TICK_CYC)
) chk_u (
    .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cfg_mode(cfg_mode), .ext_trig(ext_trig),
    .host_link_up(host_link_up), .up_ready(up_ready),
    .conv_start(conv_start), .up_valid(up_valid), .up_data(up_data),
    .scan_busy(scan_busy), .overrun(overrun), .trig_armed(trig_armed),
    .status_led(status_led)
);

// ---- verification/asq_conv_model.sv ----
// Converter model: one result for each start pulse.
// Assumes no new start while a conversion is pending.
`include "asq_params.svh"

module asq_conv_model (
    // Clock
    input wire logic sys_clk,
    // Converter
    input wire logic conv_start,
    input wire logic [`ASQ_CHAN_W-1:0] conv_chan,
    input wire logic slow,
    output logic conv_done,
    output logic [`ASQ_DATA_W-1:0] conv_data,
    // Results given so far
    output int count
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        conv_done = 1'b0;
        conv_data = 12'hFFF;
        count = 0;
    end

    // Result carries its serial number and channel
    always @(posedge sys_clk) begin
        if (conv_start === 1'b1) begin
            repeat (slow ? 5 : 1) @(posedge sys_clk);
            #1;
            conv_done = 1'b1;
            conv_data = {count[8:0], conv_chan};
            count++;
            @(posedge sys_clk);
            #1;
            conv_done = 1'b0;
            conv_data = ~conv_data;
        end
    end
endmodule

// ---- verification/tb_analog_acquisition_sequencer.sv ----
// Self-checking bench of the acquisition sequencer.
// Assumes asq_chk is bound and the converter model answers.
`include "asq_params.svh"

module tb_analog_acquisition_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CP = 8;
    localparam int BP = 5;
    logic sys_clk = 1'b0;
    logic srst, cmd_valid, cfg_trig_en, ext_trig, up_ready, host_link_up;
    logic slow, conv_start, conv_done, up_valid, scan_busy, overrun;
    logic trig_armed, status_led;
    logic [1:0] cfg_chan_count;
    logic [`ASQ_CHAN_W-1:0] cfg_first_chan, conv_chan;
    logic [`ASQ_DATA_W-1:0] conv_data, up_data, w;
    asq_pkg::asq_cmd_type cmd_code;
    asq_pkg::asq_mode_type cfg_mode;
    int fails, checks, seed, cnt, base, n, i;

    always #5 sys_clk = ~sys_clk;

    asq_sequencer #(
        .CONT_PACE_CYC(CP), .BURST_PACE_CYC(BP), .BLINK_TICK_CYC(10)
    ) dut_u (
        .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cfg_mode(cfg_mode),
        .cfg_chan_count(cfg_chan_count), .cfg_first_chan(cfg_first_chan),
        .cfg_trig_en(cfg_trig_en), .ext_trig(ext_trig),
        .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_done(conv_done), .conv_data(conv_data),
        .up_valid(up_valid), .up_data(up_data), .up_ready(up_ready),
        .scan_busy(scan_busy), .overrun(overrun), .trig_armed(trig_armed),
        .host_link_up(host_link_up), .status_led(status_led)
    );

    asq_conv_model conv_u (
        .sys_clk(sys_clk), .conv_start(conv_start), .conv_chan(conv_chan),
        .slow(slow), .conv_done(conv_done), .conv_data(conv_data),
        .count(cnt)
    );

    // ----
    // Checks and bus tasks
    // ----
    task stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk_word(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Serial number and channel of scan sample j
    function automatic logic [11:0] exp_word(input int s, input int j);
        int nch;
        nch = (cfg_chan_count == 2'h0) ? 1 : (cfg_chan_count == 2'h1) ? 2 : 4;
        return {s[8:0], 3'(cfg_first_chan + j % nch)};
    endfunction

    task cmd(input asq_pkg::asq_cmd_type c);
        cmd_code = c;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task cyc(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    task led_rises(input int c, output int r);
        logic prev;
        prev = status_led;
        r = 0;
        repeat (c) begin
            @(posedge sys_clk);
            r += int'(status_led && !prev);
            prev = status_led;
        end
        #1;
    endtask

    // Host sink with random stalls
    task take(output logic [11:0] d);
        int t;
        t = 0;
        forever begin
            up_ready = ($random(seed) & 3) != 0;
            @(posedge sys_clk);
            if (up_valid === 1'b1 && up_ready) begin
                d = up_data;
                break;
            end
            #1;
            t++;
            if (t > 2000) begin
                fails++;
                stop_test();
            end
        end
        #1;
    endtask

    task drain(input int num, input int j0);
        logic [11:0] d;
        for (int q = 0; q < num; q++) begin
            take(d);
            chk_word(d, exp_word(base + j0 + q, j0 + q));
        end
        up_ready = 1'b0;
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        seed = 32'hFC19;
        {srst, cmd_valid, cfg_trig_en, ext_trig} = 4'h8;
        {up_ready, host_link_up, slow, cfg_chan_count} = 5'h00;
        cfg_first_chan = 3'h0;
        cmd_code = asq_pkg::ASQ_CMD_SINGLE;
        cfg_mode = asq_pkg::ASQ_MODE_SW;
        repeat (16) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        chk_flag(|{conv_start, up_valid, scan_busy, overrun, status_led}, 0);
        host_link_up = 1'b1;
        led_rises(150, n);
        chk_flag(n == 3, 1);
        cyc(30);
        chk_flag(status_led, 1);
        $display("test reset and greeting done");
        for (i = 0; i < 6; i++) begin
            cfg_first_chan = $random(seed);
            slow = $random(seed);
            base = cnt;
            cmd(asq_pkg::ASQ_CMD_SINGLE);
            cmd(asq_pkg::ASQ_CMD_SINGLE);
            take(w);
            up_ready = 1'b0;
            chk_word(w, exp_word(base, 0));
            chk_flag(scan_busy, 0);
            cyc(20);
            chk_flag(up_valid, 0);
        end
        cmd(asq_pkg::ASQ_CMD_START);
        chk_flag(scan_busy, 0);
        $display("test single done");
        slow = 1'b0;
        cfg_mode = asq_pkg::ASQ_MODE_CONT;
        for (i = 0; i < 3; i++) begin
            cfg_chan_count = 2'(i);
            cfg_first_chan = $random(seed);
            base = cnt;
            cmd(asq_pkg::ASQ_CMD_START);
            led_rises(10 * CP, n);
            chk_flag(n > 0, 1);
            n = cnt - base;
            chk_flag(n >= 8 && n <= 10, 1);
            drain(n, 0);
            cmd(asq_pkg::ASQ_CMD_STOP);
            cyc(20);
            drain(cnt - base - n, n);
            cyc(20);
            chk_flag(up_valid | scan_busy, 0);
        end
        $display("test continuous done");
        cfg_mode = asq_pkg::ASQ_MODE_BURST;
        cfg_trig_en = 1'b1;
        cfg_chan_count = 2'h3;
        base = cnt;
        cmd(asq_pkg::ASQ_CMD_START);
        chk_flag(trig_armed, 1);
        led_rises(120, n);
        chk_flag(n > 0 && n < 3, 1);
        chk_flag(cnt == base, 1);
        ext_trig = 1'b1;
        cyc(2);
        chk_flag(trig_armed, 0);
        cyc(20 * BP);
        chk_flag(up_valid, 0);
        cmd(asq_pkg::ASQ_CMD_STOP);
        cyc(20);
        drain(cnt - base, 0);
        ext_trig = 1'b0;
        cmd(asq_pkg::ASQ_CMD_START);
        cmd(asq_pkg::ASQ_CMD_STOP);
        chk_flag(scan_busy, 0);
        cfg_trig_en = 1'b0;
        cfg_chan_count = 2'h0;
        base = cnt;
        cmd(asq_pkg::ASQ_CMD_START);
        n = 0;
        while (scan_busy === 1'b1 && n < 4096 * BP + 500) begin
            cyc(1);
            n++;
        end
        chk_flag(cnt - base == 4096, 1);
        drain(4096, 0);
        cyc(20);
        chk_flag(up_valid, 0);
        $display("test burst done");
        cfg_mode = asq_pkg::ASQ_MODE_CONT;
        base = cnt;
        cmd(asq_pkg::ASQ_CMD_START);
        cyc(4300 * CP);
        chk_flag(overrun, 1);
        cmd(asq_pkg::ASQ_CMD_STOP);
        cyc(20);
        // Full store plus the word waiting on the stream
        drain(`ASQ_FIFO_DEPTH + 1, 0);
        cyc(20);
        chk_flag(up_valid, 0);
        cmd(asq_pkg::ASQ_CMD_START);
        chk_flag(overrun, 0);
        cmd(asq_pkg::ASQ_CMD_STOP);
        $display("test overrun done");
        host_link_up = 1'b0;
        cyc(3);
        chk_flag(status_led, 0);
        host_link_up = 1'b1;
        cyc(200);
        chk_flag(status_led, 1);
        $display("test link loss done");
        stop_test();
    end

    initial begin
        #1000000;
        fails++;
        stop_test();
    end
endmodule
